// *** hdl/adc_cfg_pkg.sv ***
// Constants for the converter clock, timing and status register group
package adc_cfg_pkg;
    localparam logic [4:0] ADDR_CLOCK_DIV = 5'h0D;
    localparam logic [4:0] ADDR_CONV_TIMING = 5'h0E;
    localparam logic [4:0] ADDR_IFACE_PROT = 5'h0F;
    localparam logic [4:0] ADDR_SWITCH_IO = 5'h10;
    localparam logic [4:0] ADDR_POWER_TRIM = 5'h11;
    localparam logic [4:0] ADDR_MOD_STATUS = 5'h12;

    localparam logic [7:0] CLOCK_DIV_RESET = 8'h22;
    localparam logic [7:0] CONV_TIMING_RESET = 8'h01;
    localparam logic [7:0] IFACE_PROT_RESET = 8'h00;
    localparam logic [7:0] SWITCH_IO_RESET = 8'h00;
    localparam logic [7:0] POWER_TRIM_RESET = 8'h00;

    // Bits that software may store; the rest stay zero
    localparam logic [7:0] IFACE_PROT_MASK = 8'hFB;
    localparam logic [7:0] SWITCH_IO_MASK = 8'hBF;

    localparam int MOD_DIV_LSB = 5;
    localparam int SRC_DIV_LSB = 2;
    localparam int MONITOR_BIT = 1;
    localparam int SOURCE_BIT = 0;
    localparam int DELAY_LSB = 5;
    localparam int TIMEOUT_LSB = 6;
    localparam int CHECK_MODE_LSB = 4;
    localparam int DATA_CHECK_BIT = 3;
    localparam int START_BIT = 2;
    localparam int RANGE_LSB = 0;
    localparam int COMBUF_BIT = 5;
    localparam int COMSW_BIT = 4;
    localparam int SHORT_BIT = 2;
    localparam int RANGE_ERR_BIT = 7;
    localparam int CHECK_ERR_BIT = 6;
    localparam int CLK_FAULT_BIT = 4;

    localparam logic [1:0] CHECK_NONE = 2'h0;
    localparam logic [1:0] CHECK_XOR = 2'h1;
    localparam logic [1:0] CHECK_CRC8 = 2'h2;
    localparam logic [1:0] CHECK_CRC4 = 2'h3;
    localparam logic [7:0] CRC8_POLY = 8'h07;
    localparam logic [3:0] CRC4_POLY = 4'h3;

    localparam logic [12:0] TIMEOUT_SHORT = 13'h0100;
    localparam logic [12:0] TIMEOUT_MID = 13'h0400;
    localparam logic [12:0] TIMEOUT_LONG = 13'h1000;
    localparam logic [13:0] DELAY_UNIT_MOD = 14'h0040;
    localparam logic [7:0] CLOCK_LOSS_CYCLES = 8'h10;
endpackage

// *** hdl/ext_clock_watch.sv ***
// Loss-of-clock watchdog for the external clock source
`timescale 1ns/1ns
`default_nettype none
module ext_clock_watch
    import adc_cfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_watch_enable,
    input wire logic i_ext_tick,
    output logic o_ext_fail
);
    logic [7:0] idle_r;
    logic fail_r;
    wire expired = (idle_r == CLOCK_LOSS_CYCLES - 8'h01);

    always_ff @(posedge i_clock) begin
        if (i_reset || !i_watch_enable || i_ext_tick) begin
            idle_r <= 8'h00;
            fail_r <= 1'b0;
        end else if (expired) begin
            fail_r <= 1'b1;
        end else begin
            idle_r <= idle_r + 8'h01;
        end
    end

    assign o_ext_fail = fail_r;
endmodule
`default_nettype wire

// *** hdl/data_check_gen.sv ***
// Check byte generator for 24-bit conversion results
`timescale 1ns/1ns
`default_nettype none
module data_check_gen
    import adc_cfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [1:0] i_mode,
    input wire logic i_valid,
    input wire logic [23:0] i_data,
    output logic [7:0] o_check,
    output logic o_check_valid
);
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC8_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    function automatic logic [3:0] crc4(input logic [23:0] d);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 23; i >= 0; i--) begin
            c = (c[3] ^ d[i]) ? ({c[2:0], 1'b0} ^ CRC4_POLY) : {c[2:0], 1'b0};
        end
        return c;
    endfunction

    wire [7:0] xor_sum = i_data[23:16] ^ i_data[15:8] ^ i_data[7:0];
    wire [7:0] check_nxt = (i_mode == CHECK_CRC8) ? crc8(i_data) :
        (i_mode == CHECK_CRC4) ? {4'h0, crc4(i_data)} : xor_sum;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_check <= 8'h00;
            o_check_valid <= 1'b0;
        end else begin
            o_check_valid <= i_valid;
            if (i_valid) begin
                o_check <= check_nxt;
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/adc_config_status_regs.sv ***
// Clock, timing, protection and status register group of the converter
// Contract
// R1 - Modulator divider codes 0..7 divide by 2,4,6,8,12,16,32,40; reset divide-by-4
// R2 - Source divider codes 0..7 divide by 1 to 128 in powers of two
// R3 - Monitor on: lost external clock sets failure and falls back to internal
// R4 - Source select 0 picks external clock, 1 picks internal oscillator
// R5 - Same source value written twice powers down the unused oscillator; the internal one stays on while the monitor bit is 1
// R6 - Delay before each start is 0,1,4,10,25,50,125,250 times 64 modulator ticks
// R7 - Serial reset after 256, 1024 or 4096 idle system ticks; code 0 off
// R8 - Check mode selects none, XOR sum, CRC-8 or CRC-4; code 0 (none) gives the XOR sum here
// R9 - Data check enable appends a check byte over 24 data bits
// R10 - Writing start bit 1 launches a conversion; 0 does nothing
// R11 - Range select sets threshold at reference, half or double; 0 off
// R12 - Range error flag in status bit 7, routed to pin when configured
// R13 - Check error flag in status bit 6, cleared by a status read
// R14 - Ground switch closes while converting, opens in power-down, when enabled
// R15 - Common drive enabled outside power-down when its bit is set
// R16 - Short protection lowers drive strength of shorted outputs
// R17 - Host clears precharge enable when both dividers are code 0
// R18 - Reset loads 22h, 01h and 00h into the registers
// R19 - Interrupt route sends clock fault and range events to D0 or D1
// R20 - Clock fault status reads 1 while running on fallback oscillator
// R21 - Writes to read-only or reserved bits are ignored; reserved read zero
`timescale 1ns/1ns
`default_nettype none
module adc_config_status_regs
    import adc_cfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [4:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_write_check_fail,
    input wire logic i_ext_clock_tick,
    input wire logic i_int_osc_tick,
    input wire logic i_sclk_active,
    input wire logic i_conv_request,
    input wire logic i_conv_data_valid,
    input wire logic [23:0] i_conv_data,
    input wire logic i_range_vref,
    input wire logic i_range_half,
    input wire logic i_range_double,
    input wire logic i_converting,
    input wire logic i_power_down,
    input wire logic i_short_detect,
    input wire logic [1:0] i_interrupt_pin_route,
    output logic o_sys_clock_tick,
    output logic o_mod_clock_tick,
    output logic o_use_internal_osc,
    output logic o_int_osc_off,
    output logic o_ext_osc_off,
    output logic o_conv_start,
    output logic o_delay_active,
    output logic o_serial_reset,
    output logic [1:0] o_check_mode,
    output logic [7:0] o_check_byte,
    output logic o_check_byte_valid,
    output logic o_ground_switch_close,
    output logic o_common_drive,
    output logic o_reduce_drive,
    output logic [7:0] o_analog_power_trim,
    output logic o_pin0_irq_enable,
    output logic o_pin0_irq,
    output logic o_pin1_irq_enable,
    output logic o_pin1_irq
);
    typedef enum logic {DELAY_IDLE, DELAY_WAIT} delay_state_t;

    function automatic logic [5:0] mod_div(input logic [2:0] code);
        case (code)
            3'h0: mod_div = 6'h02;
            3'h1: mod_div = 6'h04;
            3'h2: mod_div = 6'h06;
            3'h3: mod_div = 6'h08;
            3'h4: mod_div = 6'h0C;
            3'h5: mod_div = 6'h10;
            3'h6: mod_div = 6'h20;
            default: mod_div = 6'h28;
        endcase
    endfunction

    function automatic logic [13:0] delay_ticks(input logic [2:0] code);
        logic [7:0] mult;
        case (code)
            3'h0: mult = 8'h00;
            3'h1: mult = 8'h01;
            3'h2: mult = 8'h04;
            3'h3: mult = 8'h0A;
            3'h4: mult = 8'h19;
            3'h5: mult = 8'h32;
            3'h6: mult = 8'h7D;
            default: mult = 8'hFA;
        endcase
        delay_ticks = 14'(mult * DELAY_UNIT_MOD);
    endfunction

    function automatic logic [12:0] idle_limit(input logic [1:0] code);
        case (code)
            2'h1: idle_limit = TIMEOUT_SHORT;
            2'h2: idle_limit = TIMEOUT_MID;
            default: idle_limit = TIMEOUT_LONG;
        endcase
    endfunction

    logic [7:0] clock_div_r;
    logic [7:0] timing_r;
    logic [7:0] iface_r;
    logic [7:0] switch_io_r;
    logic [7:0] trim_r;
    logic range_err_r;
    logic check_err_r;
    logic src_written_r;
    logic last_src_r;
    logic int_off_r;
    logic ext_off_r;
    logic [6:0] src_cnt_r;
    logic [5:0] mod_cnt_r;
    logic sys_tick_r;
    logic mod_tick_r;
    logic [12:0] idle_cnt_r;
    logic serial_reset_r;
    logic [13:0] delay_cnt_r;
    delay_state_t delay_state_r;
    logic conv_start_r;
    logic ext_fail;

    wire wr_div = i_reg_write && (i_reg_addr == ADDR_CLOCK_DIV);
    wire wr_timing = i_reg_write && (i_reg_addr == ADDR_CONV_TIMING);
    wire wr_iface = i_reg_write && (i_reg_addr == ADDR_IFACE_PROT);
    wire wr_switch = i_reg_write && (i_reg_addr == ADDR_SWITCH_IO);
    wire wr_trim = i_reg_write && (i_reg_addr == ADDR_POWER_TRIM);
    wire rd_status = i_reg_read && (i_reg_addr == ADDR_MOD_STATUS);

    wire [2:0] mod_div_code = clock_div_r[MOD_DIV_LSB +: 3];
    wire [2:0] src_div_code = clock_div_r[SRC_DIV_LSB +: 3];
    wire monitor_on = clock_div_r[MONITOR_BIT];
    wire src_internal = clock_div_r[SOURCE_BIT];
    wire [2:0] delay_code = timing_r[DELAY_LSB +: 3];
    wire [1:0] timeout_code = iface_r[TIMEOUT_LSB +: 2];
    wire [1:0] range_sel = iface_r[RANGE_LSB +: 2];

    // Fallback only while the external source is the one selected
    wire use_internal = src_internal || ext_fail; // R3 R4
    wire src_tick = use_internal ? i_int_osc_tick : i_ext_clock_tick; // R4
    wire [6:0] src_last = 7'((8'h01 << src_div_code) - 8'h01);
    wire src_wrap = src_tick && (src_cnt_r == src_last); // R2
    wire [5:0] mod_last = mod_div(mod_div_code) - 6'h01;
    wire mod_wrap = sys_tick_r && (mod_cnt_r == mod_last); // R1

    wire start_req = (wr_iface && i_reg_wdata[START_BIT]) || i_conv_request;
    wire range_hit = (range_sel == 2'h1 && i_range_vref) ||
        (range_sel == 2'h2 && i_range_half) ||
        (range_sel == 2'h3 && i_range_double); // R11
    wire idle_expired = (timeout_code != 2'h0) && !i_sclk_active &&
        sys_tick_r && (idle_cnt_r >= idle_limit(timeout_code) - 13'h0001);
    wire [7:0] status_word = {range_err_r, check_err_r, 1'b0, ext_fail,
        4'h0}; // R12 R13 R20 R21

    wire [7:0] rdata_nxt =
        (i_reg_addr == ADDR_CLOCK_DIV) ? clock_div_r :
        (i_reg_addr == ADDR_CONV_TIMING) ? timing_r :
        (i_reg_addr == ADDR_IFACE_PROT) ? iface_r :
        (i_reg_addr == ADDR_SWITCH_IO) ? switch_io_r :
        (i_reg_addr == ADDR_POWER_TRIM) ? trim_r :
        (i_reg_addr == ADDR_MOD_STATUS) ? status_word : 8'h00;

    ext_clock_watch u_watch (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_watch_enable(monitor_on && !src_internal), // R3
        .i_ext_tick(i_ext_clock_tick),
        .o_ext_fail(ext_fail)
    );

    data_check_gen u_check (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_mode(iface_r[CHECK_MODE_LSB +: 2]), // R8
        .i_valid(i_conv_data_valid && iface_r[DATA_CHECK_BIT]), // R9
        .i_data(i_conv_data),
        .o_check(o_check_byte),
        .o_check_valid(o_check_byte_valid)
    );

    // Register file; the start bit is a strobe and never stored
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            clock_div_r <= CLOCK_DIV_RESET; // R18
            timing_r <= CONV_TIMING_RESET; // R18
            iface_r <= IFACE_PROT_RESET;
            switch_io_r <= SWITCH_IO_RESET;
            trim_r <= POWER_TRIM_RESET;
            o_reg_rdata <= 8'h00;
        end else begin
            if (wr_div) clock_div_r <= i_reg_wdata;
            if (wr_timing) timing_r <= i_reg_wdata;
            if (wr_iface) iface_r <= i_reg_wdata & IFACE_PROT_MASK; // R10
            if (wr_switch) switch_io_r <= i_reg_wdata & SWITCH_IO_MASK; // R21
            if (wr_trim) trim_r <= i_reg_wdata;
            if (i_reg_read) o_reg_rdata <= rdata_nxt;
        end
    end

    // Status flags: a new event in the read cycle survives the clear
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            range_err_r <= 1'b0;
            check_err_r <= 1'b0;
        end else begin
            range_err_r <= range_hit || (range_err_r && !rd_status); // R12
            check_err_r <= i_write_check_fail ||
                (check_err_r && !rd_status); // R13
        end
    end

    // Oscillator power-down on a repeated source select value
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            src_written_r <= 1'b0;
            last_src_r <= 1'b0;
            int_off_r <= 1'b0;
            ext_off_r <= 1'b0;
        end else if (wr_div) begin
            src_written_r <= 1'b1;
            last_src_r <= i_reg_wdata[SOURCE_BIT];
            if (i_reg_wdata[SOURCE_BIT]) begin
                int_off_r <= 1'b0;
                ext_off_r <= src_written_r && last_src_r; // R5
            end else begin
                ext_off_r <= 1'b0;
                int_off_r <= src_written_r && !last_src_r &&
                    !i_reg_wdata[MONITOR_BIT]; // R5
            end
        end
    end

    // Source and modulator dividers as tick enables
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            src_cnt_r <= 7'h00;
            mod_cnt_r <= 6'h00;
            sys_tick_r <= 1'b0;
            mod_tick_r <= 1'b0;
        end else begin
            sys_tick_r <= src_wrap; // R2
            mod_tick_r <= mod_wrap; // R1
            if (src_wrap || src_cnt_r > src_last) src_cnt_r <= 7'h00;
            else if (src_tick) src_cnt_r <= src_cnt_r + 7'h01;
            // A smaller divider written mid-count must not run to overflow
            if (mod_wrap || mod_cnt_r > mod_last) mod_cnt_r <= 6'h00;
            else if (sys_tick_r) mod_cnt_r <= mod_cnt_r + 6'h01; // R1
        end
    end

    // Serial idle timeout counted in system clock periods
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            idle_cnt_r <= 13'h0000;
            serial_reset_r <= 1'b0;
        end else begin
            serial_reset_r <= idle_expired; // R7
            if (i_sclk_active || timeout_code == 2'h0 || idle_expired)
                idle_cnt_r <= 13'h0000;
            else if (sys_tick_r) idle_cnt_r <= idle_cnt_r + 13'h0001; // R7
        end
    end

    // Pre-conversion delay; a start during a wait restarts the wait
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            delay_state_r <= DELAY_IDLE;
            delay_cnt_r <= 14'h0000;
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= 1'b0;
            case (delay_state_r)
                DELAY_IDLE: begin
                    if (start_req && delay_code == 3'h0) begin
                        conv_start_r <= 1'b1; // R10
                    end else if (start_req) begin
                        delay_cnt_r <= delay_ticks(delay_code); // R6
                        delay_state_r <= DELAY_WAIT;
                    end
                end
                DELAY_WAIT: begin
                    if (start_req) begin
                        delay_cnt_r <= delay_ticks(delay_code);
                    end else if (mod_tick_r && delay_cnt_r == 14'h0001) begin
                        conv_start_r <= 1'b1; // R6
                        delay_state_r <= DELAY_IDLE;
                    end else if (mod_tick_r) begin
                        delay_cnt_r <= delay_cnt_r - 14'h0001;
                    end
                end
                default: delay_state_r <= DELAY_IDLE;
            endcase
        end
    end

    assign o_sys_clock_tick = sys_tick_r;
    assign o_mod_clock_tick = mod_tick_r;
    assign o_use_internal_osc = use_internal;
    assign o_int_osc_off = int_off_r;
    assign o_ext_osc_off = ext_off_r;
    assign o_conv_start = conv_start_r;
    assign o_delay_active = (delay_state_r == DELAY_WAIT);
    assign o_serial_reset = serial_reset_r;
    assign o_check_mode = iface_r[CHECK_MODE_LSB +: 2];
    assign o_ground_switch_close = switch_io_r[COMSW_BIT] && i_converting &&
        !i_power_down; // R14
    assign o_common_drive = switch_io_r[COMBUF_BIT] && !i_power_down; // R15
    assign o_reduce_drive = switch_io_r[SHORT_BIT] && i_short_detect; // R16
    assign o_analog_power_trim = trim_r;
    // Route 1: both on D0, 2: both on D1, 3: fault D0 and range D1
    assign o_pin0_irq_enable = (i_interrupt_pin_route == 2'h1) ||
        (i_interrupt_pin_route == 2'h3); // R19
    assign o_pin1_irq_enable = (i_interrupt_pin_route == 2'h2) ||
        (i_interrupt_pin_route == 2'h3); // R19
    assign o_pin0_irq = (i_interrupt_pin_route == 2'h1) ?
        (ext_fail || range_err_r) :
        (i_interrupt_pin_route == 2'h3) ? ext_fail : 1'b0; // R12 R19
    assign o_pin1_irq = (i_interrupt_pin_route == 2'h2) ?
        (ext_fail || range_err_r) :
        (i_interrupt_pin_route == 2'h3) ? range_err_r : 1'b0; // R12 R19

    property p_reset_values;
        @(posedge i_clock) i_reset |=>
            clock_div_r == CLOCK_DIV_RESET && timing_r == CONV_TIMING_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values) // R18
        else $error("register reset values wrong");

    property p_start_now;
        @(posedge i_clock) disable iff (i_reset)
            wr_iface && i_reg_wdata[START_BIT] && delay_code == 3'h0 &&
            delay_state_r == DELAY_IDLE |=> o_conv_start;
    endproperty
    a_start_now: assert property (p_start_now) // R10
        else $error("start write without delay did not start");

    property p_start_zero;
        @(posedge i_clock) disable iff (i_reset)
            !start_req && delay_state_r == DELAY_IDLE |=> !o_conv_start;
    endproperty
    a_start_zero: assert property (p_start_zero) // R10
        else $error("conversion started without a request");

    property p_delay_holds;
        @(posedge i_clock) disable iff (i_reset)
            start_req && delay_code == 3'h1 && delay_state_r == DELAY_IDLE
            |=> (!o_conv_start && o_delay_active) [*8];
    endproperty
    a_delay_holds: assert property (p_delay_holds) // R6
        else $error("delayed start came too early");

    property p_check_err;
        @(posedge i_clock) disable iff (i_reset)
            i_write_check_fail |=> status_word[CHECK_ERR_BIT] ##1
            (status_word[CHECK_ERR_BIT] || $past(rd_status));
    endproperty
    a_check_err: assert property (p_check_err) // R13
        else $error("check error flag not held until read");

    property p_fallback;
        @(posedge i_clock) disable iff (i_reset)
            ext_fail |-> o_use_internal_osc && status_word[CLK_FAULT_BIT];
    endproperty
    a_fallback: assert property (p_fallback) // R3
        else $error("no fallback on clock failure");

    property p_fault_clear;
        @(posedge i_clock) disable iff (i_reset)
            $past(!monitor_on || i_ext_clock_tick) |-> !ext_fail;
    endproperty
    a_fault_clear: assert property (p_fault_clear) // R20
        else $error("clock fault flag not cleared");

    property p_timeout_off;
        @(posedge i_clock) disable iff (i_reset)
            $past(timeout_code == 2'h0) |-> !o_serial_reset;
    endproperty
    a_timeout_off: assert property (p_timeout_off) // R7
        else $error("serial reset while timeout disabled");

    property p_int_off;
        @(posedge i_clock) disable iff (i_reset)
            wr_div && !i_reg_wdata[SOURCE_BIT] && !i_reg_wdata[MONITOR_BIT]
            && src_written_r && !last_src_r |=> o_int_osc_off;
    endproperty
    a_int_off: assert property (p_int_off) // R5
        else $error("internal oscillator not powered down");

    property p_sys_div1;
        @(posedge i_clock) disable iff (i_reset)
            src_div_code == 3'h0 && $stable(src_div_code) && src_tick
            |=> o_sys_clock_tick;
    endproperty
    a_sys_div1: assert property (p_sys_div1) // R2
        else $error("source divide by one lost a tick");

    c_delayed_start: cover property (@(posedge i_clock)
        o_delay_active ##1 o_conv_start);
    c_fallback: cover property (@(posedge i_clock) ext_fail);
    c_serial_reset: cover property (@(posedge i_clock) o_serial_reset);
endmodule
`default_nettype wire

// *** dv/reg_host_model.sv ***
// Host model issuing single-byte register accesses
`timescale 1ns/1ns
`default_nettype none
module reg_host_model (
    input wire logic i_clock,
    input wire logic [7:0] i_rdata,
    output logic o_write,
    output logic o_read,
    output logic [4:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_write = 1'b0;
        o_read = 1'b0;
        o_addr = 5'h00;
        o_wdata = 8'h00;
    end
    // Idle bus shows inverted values so stale data is never mistaken
    task automatic access(input logic w, input logic [4:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge i_clock);
        o_addr = a;
        o_wdata = d;
        o_write = w;
        o_read = ~w;
        @(negedge i_clock);
        q = i_rdata;
        o_write = 1'b0;
        o_read = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// *** dv/adc_config_status_regs_test.sv ***
// Self-checking bench for the converter register group
`timescale 1ns/1ns
`default_nettype none
module adc_config_status_regs_test;
    import adc_cfg_pkg::*;
    logic i_clock = 1'b0, i_reset = 1'b1, wr, rd, fl = 1'b0, et = 1'b1;
    logic sk = 1'b1, vr = 1'b0, cv = 1'b0, pd = 1'b0, sh = 1'b0, dv = 1'b0;
    logic z = 1'b0, srs, cst, io, p0, gs, cd, rdv, cbv;
    logic it = 1'b0, st, ioff, eoff, da, p1, e0, e1;
    logic [4:0] ad;
    logic [7:0] wd, rdat, q, cb, tr;
    logic [23:0] dat = 24'h000000;
    logic [1:0] rt = 2'h0, cm;
    int err_total = 0, samples_checked = 0, n;
    adc_config_status_regs dut (.i_clock(i_clock), .i_reset(i_reset),
        .i_reg_write(wr), .i_reg_read(rd), .i_reg_addr(ad), .i_reg_wdata(wd),
        .o_reg_rdata(rdat), .i_write_check_fail(fl), .i_ext_clock_tick(et),
        .i_int_osc_tick(it), .i_sclk_active(sk), .i_conv_request(z),
        .i_conv_data_valid(dv), .i_conv_data(dat), .i_range_vref(vr),
        .i_range_half(z), .i_range_double(z), .i_converting(cv),
        .i_power_down(pd), .i_short_detect(sh), .i_interrupt_pin_route(rt),
        .o_sys_clock_tick(st), .o_mod_clock_tick(), .o_use_internal_osc(io),
        .o_int_osc_off(ioff), .o_ext_osc_off(eoff), .o_conv_start(cst),
        .o_delay_active(da), .o_serial_reset(srs), .o_check_mode(cm),
        .o_check_byte(cb), .o_check_byte_valid(cbv),
        .o_ground_switch_close(gs), .o_common_drive(cd), .o_reduce_drive(rdv),
        .o_analog_power_trim(tr), .o_pin0_irq_enable(e0), .o_pin0_irq(p0),
        .o_pin1_irq_enable(e1), .o_pin1_irq(p1));
    reg_host_model host (.i_clock(i_clock), .i_rdata(rdat), .o_write(wr),
        .o_read(rd), .o_addr(ad), .o_wdata(wd));
    initial forever #50 i_clock = ~i_clock;
    task automatic final_report;
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, q);
        chk("rdata", e, q);
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q);
    endtask
    wire [3:0] watch = {cbv, io, srs, cst};
    // Bounded wait at falling edges; a miss ends the run at once
    task automatic wt(input int k, input logic v, input int lim, output int c);
        c = 0;
        while (watch[k] !== v && c < lim) begin
            @(negedge i_clock);
            c++;
        end
        chk("wait", {7'h00, v}, {7'h00, watch[k]});
        if (watch[k] !== v)
            final_report();
    endtask
    task automatic t_regs;
        rchk(ADDR_CLOCK_DIV, 8'h22);
        rchk(ADDR_CONV_TIMING, 8'h01);
        for (int a = 15; a <= 18; a++) begin
            rchk(a[4:0], 8'h00);
        end
        rchk(5'h1F, 8'h00);
        wreg(ADDR_CLOCK_DIV, 8'hE2);
        rchk(ADDR_CLOCK_DIV, 8'hE2);
        wreg(ADDR_IFACE_PROT, 8'hFF);
        rchk(ADDR_IFACE_PROT, 8'hFB);
        wreg(ADDR_MOD_STATUS, 8'hFF);
        rchk(ADDR_MOD_STATUS, 8'h00);
        wreg(ADDR_SWITCH_IO, 8'hFF);
        rchk(ADDR_SWITCH_IO, 8'hBF);
        cv = 1'b1;
        sh = 1'b1;
        #1 chk("switch", 8'h07, {5'h00, gs, cd, rdv});
        @(negedge i_clock);
        pd = 1'b1;
        #1 chk("switch_pd", 8'h01, {5'h00, gs, cd, rdv});
        wreg(ADDR_SWITCH_IO, 8'h00);
        wreg(ADDR_IFACE_PROT, 8'h00);
    endtask
    task automatic t_start(input logic [7:0] d, input logic [7:0] e);
        wreg(ADDR_IFACE_PROT, d);
        n = 0;
        repeat (4) begin
            if (cst === 1'b1)
                n++;
            @(negedge i_clock);
        end
        chk("conv_start", e, n[7:0]);
    endtask
    task automatic t_osc;
        wreg(ADDR_POWER_TRIM, 8'hEF);
        chk("trim", 8'hEF, tr);
        wreg(ADDR_CLOCK_DIV, 8'h00);
        wreg(ADDR_CLOCK_DIV, 8'h00);
        chk("osc_off", 8'h02, {6'h00, ioff, eoff});
        wreg(ADDR_CLOCK_DIV, 8'h01);
        wreg(ADDR_CLOCK_DIV, 8'h01);
        chk("osc_off", 8'h01, {6'h00, ioff, eoff});
        chk("src", 8'h02, {6'h00, io, st});
        it = 1'b1;
        @(negedge i_clock);
        @(negedge i_clock);
        chk("src", 8'h03, {6'h00, io, st});
        it = 1'b0;
    endtask
    task automatic t_crc(input logic [7:0] cfg, input logic [7:0] e);
        wreg(ADDR_IFACE_PROT, cfg);
        chk("check_mode", {6'h00, cfg[5:4]}, {6'h00, cm});
        dat = 24'h123456;
        dv = 1'b1;
        @(negedge i_clock);
        dv = 1'b0;
        wt(3, 1'b1, 3, n);
        chk("check_byte", e, cb);
    endtask
    task automatic t_timing;
        // Modulator at half the system clock: 64 ticks are 128 cycles
        wreg(ADDR_CLOCK_DIV, 8'h02);
        wreg(ADDR_CONV_TIMING, 8'h21);
        wreg(ADDR_IFACE_PROT, 8'h04);
        chk("delay_active", 8'h01, {7'h00, da});
        wt(0, 1'b1, 200, n);
        chk("delay", 8'h01, {7'h00, n >= 124 && n <= 132});
        wreg(ADDR_CONV_TIMING, 8'h01);
        wreg(ADDR_IFACE_PROT, 8'h40);
        sk = 1'b0;
        wt(1, 1'b1, 400, n);
        chk("timeout", 8'h01, {7'h00, n >= 250 && n <= 260});
        sk = 1'b1;
        wreg(ADDR_IFACE_PROT, 8'h00);
        et = 1'b0;
        wt(2, 1'b1, 40, n);
        rchk(ADDR_MOD_STATUS, 8'h10);
        et = 1'b1;
        wt(2, 1'b0, 40, n);
        rchk(ADDR_MOD_STATUS, 8'h00);
    endtask
    task automatic t_status;
        fl = 1'b1;
        @(negedge i_clock);
        fl = 1'b0;
        rchk(ADDR_MOD_STATUS, 8'h40);
        rchk(ADDR_MOD_STATUS, 8'h00);
        wreg(ADDR_IFACE_PROT, 8'h01);
        rt = 2'h1;
        vr = 1'b1;
        @(negedge i_clock);
        vr = 1'b0;
        @(negedge i_clock);
        chk("pin_irq", 8'h05, {4'h0, e1, e0, p1, p0});
        rchk(ADDR_MOD_STATUS, 8'h80);
        rchk(ADDR_MOD_STATUS, 8'h00);
        t_crc(8'h08, 8'h70);
        t_crc(8'h28, 8'h7C);
        t_crc(8'h38, 8'h01);
    endtask
    initial begin
        repeat (5) @(negedge i_clock);
        i_reset = 1'b0;
        t_regs();
        t_start(8'h04, 8'h01);
        t_start(8'h00, 8'h00);
        t_osc();
        t_timing();
        t_status();
        final_report();
    end
endmodule
`default_nettype wire
